/* File: inc/scc_pkg.sv */
// constants shared by the sub-rate port configuration checker
package scc_pkg;

    // =====================================================================
    // register map (byte addresses on the plain register port)
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] ADDR_SEL = 8'h00;
    localparam logic [7:0] ADDR_CFG = 8'h04;
    localparam logic [7:0] ADDR_SAVED = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_MASK = 8'h14;
    localparam logic [7:0] ADDR_LINK = 8'h18;
    localparam logic [7:0] ADDR_ERR = 8'h1C;

    // =====================================================================
    // port configuration word layout
    localparam int CFG_W = 23;
    localparam int STATE_BIT = 0;
    localparam int DEST_LSB = 1;
    localparam int DEST_W = 4;
    localparam int TS_LSB = 5;
    localparam int TS_W = 5;
    localparam int FRAME_LSB = 10;
    localparam int FRAME_W = 2;
    localparam int RATE_LSB = 12;
    localparam int RATE_W = 3;
    localparam int SUB_LSB = 15;
    localparam int SUB_W = 5;
    localparam int MODE_BIT = 20;
    localparam int ECOR_LSB = 21;
    localparam int ECOR_W = 2;

    // =====================================================================
    // field encodings
    localparam logic [3:0] DEST_WAN_LAST = 4'h7;
    localparam logic [3:0] DEST_SRV_FIRST = 4'h8;
    localparam logic [3:0] DEST_SRV_LAST = 4'hA;
    localparam logic [1:0] FR_A = 2'h0;
    localparam logic [1:0] FR_B5 = 2'h1;
    localparam logic [1:0] FR_B10 = 2'h2;
    localparam logic [1:0] FR_B20 = 2'h3;
    localparam logic [2:0] R_2K4 = 3'h0;
    localparam logic [2:0] R_9K6 = 3'h2;
    localparam logic [2:0] R_19K2 = 3'h3;
    localparam logic [2:0] R_56K = 3'h4;
    localparam logic [2:0] R_64K = 3'h5;
    localparam logic [2:0] R_SW56 = 3'h6;
    localparam logic [1:0] EC_OFF = 2'h0;
    localparam logic [1:0] EC_MAJ = 2'h1;
    localparam logic [1:0] EC_BCH = 2'h2;
    localparam logic [4:0] TS_FIRST = 5'h01;
    localparam logic [4:0] TS_T1_MAX = 5'h18;
    localparam logic [4:0] TS_E1_MAX = 5'h1F;
    localparam logic [4:0] TS_E1_SIG = 5'h10;
    localparam logic [4:0] SEG_FIRST = 5'h01;
    localparam logic [4:0] SEGS_B5 = 5'h05;
    localparam logic [4:0] SEGS_B10 = 5'h0A;
    localparam logic [4:0] SEGS_B20 = 5'h14;
    localparam int SEG_MAX = 20;

    // reset value: stdby, w1-1, slot 1, DS0A, 2.4k, sub slot 1, ocu, off
    localparam logic [CFG_W-1:0] CFG_DEFAULT = 23'h008020;

    // =====================================================================
    // card variants
    localparam int VAR_TWO = 0;
    localparam int VAR_FIVE = 1;
    localparam int VAR_TEN = 2;

    // =====================================================================
    // command, link, status and error bits
    localparam int CMD_SAVE = 0;
    localparam int CMD_UNDO = 1;
    localparam int CMD_EXIT = 2;
    localparam int LINK_E1 = 0;
    localparam int LINK_SIG = 1;
    localparam int STAT_W = 5;
    localparam int ST_SAVED = 0;
    localparam int ST_RANGE = 1;
    localparam int ST_SLOT = 2;
    localparam int ST_OVL = 3;
    localparam int ST_EXIT = 4;
    localparam int ERR_W = 3;
    localparam int ERR_RANGE = 0;
    localparam int ERR_SLOT = 1;
    localparam int ERR_OVL = 2;
    localparam int ERR_DIRTY = 3;
    localparam int ERR_BUSY = 4;

endpackage

/* File: core/scc_cfg_mem.sv */
// small memory of committed port configuration words
`timescale 1ns/1ps

module scc_cfg_mem #(
    parameter int WIDTH = 23,
    parameter int DEPTH = 2,
    parameter int AW = 1
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] rdata_ff;

    // every word must be reachable through the address
    if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
        $error("depth does not fit the address width");
    end

    // contents need no reset: the owner writes every word after reset
    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            rdata_ff <= '0;
        end else begin
            rdata_ff <= mem[raddr];
        end
    end

    assign rdata = rdata_ff;

endmodule

/* File: core/scc_port_cfg.sv */
// per-port sub-rate configuration checker with staged save and undo
`timescale 1ns/1ps

module scc_port_cfg import scc_pkg::*; #(
    parameter int NUM_PORTS = 2,
    parameter int VARIANT = VAR_TWO
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rdata,
    output logic irq,
    output logic unsaved
);

    localparam int IW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;
    localparam logic [IW-1:0] LAST_IDX = IW'(NUM_PORTS - 1);

    // =====================================================================
    // elaboration check
    if (NUM_PORTS < 1 || NUM_PORTS > ((VARIANT == VAR_TWO) ? 2 : 10)
        || VARIANT < VAR_TWO || VARIANT > VAR_TEN) begin : g_bad_cfg
        $error("port count does not fit the card variant");
    end

    typedef enum logic [1:0] {ST_IDLE, ST_SAVE, ST_UNDO} scc_seq_t;

    // =====================================================================
    // helpers
    function automatic logic [4:0] frame_len(input logic [1:0] fr);
        frame_len = (fr == FR_B5) ? SEGS_B5 : (fr == FR_B10) ? SEGS_B10 :
                    (fr == FR_B20) ? SEGS_B20 : SEG_FIRST;
    endfunction

    // segments taken: one segment is 9.6k, 4.8k or 2.4k by framing; 0 = no fit
    function automatic logic [4:0] seg_count(input logic [1:0] fr, input logic [2:0] rt);
        logic [4:0] units;
        logic [4:0] q;
        units = 5'h01 << rt;
        q = (fr == FR_B5) ? (units >> 2) : (fr == FR_B10) ? (units >> 1) : units;
        if (fr == FR_A) begin
            seg_count = 5'h01;
        end else if (rt > R_19K2) begin
            seg_count = 5'h00;
        end else begin
            seg_count = (q == 5'h00) ? 5'h01 : q;
        end
    endfunction

    function automatic logic [SEG_MAX-1:0] seg_mask(input logic [4:0] start,
                                                    input logic [4:0] cnt);
        logic [SEG_MAX-1:0] m;
        m = (SEG_MAX'(1) << cnt) - SEG_MAX'(1);
        seg_mask = m << (start - SEG_FIRST);
    endfunction

    // =====================================================================
    // state
    logic [CFG_W-1:0] pend_ff [NUM_PORTS];
    logic [IW-1:0] sel_ff, nxt_sel;
    logic [STAT_W-1:0] status_ff, nxt_status, mask_ff;
    logic [ERR_W-1:0] err_ff, nxt_err;
    logic [1:0] link_ff;
    logic dirty_ff, nxt_dirty;
    logic unsaved_ff, nxt_unsaved;
    logic irq_ff;
    logic [DATA_W-1:0] rdata_ff;
    scc_seq_t seq_ff, nxt_seq;
    logic [IW-1:0] idx_ff, nxt_idx, undo_idx_ff;
    logic undo_vld_ff;
    logic [CFG_W-1:0] saved_q;

    // =====================================================================
    // register decode
    wire sel_wr = wr_en && addr == ADDR_SEL;
    wire cfg_wr = wr_en && addr == ADDR_CFG;
    wire cmd_wr = wr_en && addr == ADDR_CMD;
    wire status_rd = rd_en && addr == ADDR_STATUS;
    wire busy = seq_ff != ST_IDLE || undo_vld_ff;
    wire [CFG_W-1:0] cur_cfg = pend_ff[sel_ff];

    assign nxt_sel = (sel_wr && wdata[IW-1:0] <= LAST_IDX && wdata[DATA_W-1:IW] == '0) ?
                     wdata[IW-1:0] : sel_ff;

    // =====================================================================
    // candidate configuration fields
    wire [CFG_W-1:0] new_cfg = wdata[CFG_W-1:0];
    wire new_act = new_cfg[STATE_BIT];
    wire [3:0] new_dest = new_cfg[DEST_LSB +: DEST_W];
    wire [4:0] new_ts = new_cfg[TS_LSB +: TS_W];
    wire [1:0] new_fr = new_cfg[FRAME_LSB +: FRAME_W];
    wire [2:0] new_rate = new_cfg[RATE_LSB +: RATE_W];
    wire [4:0] new_sub = new_cfg[SUB_LSB +: SUB_W];
    wire new_csu = new_cfg[MODE_BIT];
    wire [1:0] new_ec = new_cfg[ECOR_LSB +: ECOR_W];

    // eight WAN codes then three server codes
    wire is_srv = new_dest >= DEST_SRV_FIRST && new_dest <= DEST_SRV_LAST;
    wire dest_bad = new_dest > DEST_SRV_LAST;
    wire [4:0] ts_max = link_ff[LINK_E1] ? TS_E1_MAX : TS_T1_MAX;
    wire ts_bad = !is_srv && (new_ts < TS_FIRST || new_ts > ts_max ||
                  (link_ff[LINK_E1] && link_ff[LINK_SIG] && new_ts == TS_E1_SIG));
    wire rate_bad = new_rate > R_SW56 ||
                    (is_srv && new_rate != R_56K && new_rate != R_64K);
    // correction eligibility; switched_56k_rate fits neither list
    wire maj_ok = new_rate <= R_9K6;
    wire bch_ok = VARIANT == VAR_TWO &&
                  (new_rate == R_19K2 || new_rate == R_56K || new_rate == R_64K);
    wire ec_bad = (new_ec == EC_MAJ && !maj_ok) || (new_ec == EC_BCH && !bch_ok) ||
                  new_ec > EC_BCH;
    wire mode_bad = new_csu && VARIANT == VAR_FIVE;
    wire range_bad = dest_bad || ts_bad || rate_bad || ec_bad || mode_bad;

    wire [4:0] new_cnt = seg_count(new_fr, new_rate);
    wire [5:0] new_end = {1'b0, new_sub} + {1'b0, new_cnt} - 6'h01;
    wire slot_bad = new_sub < SEG_FIRST || new_cnt == 5'h00 ||
                    new_end > {1'b0, frame_len(new_fr)};
    wire [SEG_MAX-1:0] new_mask = seg_mask(new_sub, new_cnt);

    // overlap with other active ports in the same WAN slot
    logic ovl;
    always_comb begin
        ovl = 1'b0;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (IW'(i) != sel_ff && pend_ff[i][STATE_BIT] && new_act && !is_srv &&
                pend_ff[i][DEST_LSB +: DEST_W] == new_dest &&
                pend_ff[i][TS_LSB +: TS_W] == new_ts) begin
                // mixed framings in one slot cannot share it
                if (pend_ff[i][FRAME_LSB +: FRAME_W] != new_fr || new_fr == FR_A ||
                    (seg_mask(pend_ff[i][SUB_LSB +: SUB_W],
                              seg_count(pend_ff[i][FRAME_LSB +: FRAME_W],
                                        pend_ff[i][RATE_LSB +: RATE_W])) & new_mask) != '0) begin
                    ovl = 1'b1;
                end
            end
        end
    end

    wire cfg_try = cfg_wr && !busy;
    wire cfg_acc = cfg_try && !range_bad && !slot_bad && !ovl;
    wire cfg_rej = cfg_try && !cfg_acc;

    // =====================================================================
    // save / undo sequencer
    wire seq_last = idx_ff == LAST_IDX;
    wire go_save = cmd_wr && wdata[CMD_SAVE] && !busy;
    wire go_undo = cmd_wr && wdata[CMD_UNDO] && !wdata[CMD_SAVE] && !busy;
    wire exit_req = cmd_wr && wdata[CMD_EXIT];
    wire save_done = seq_ff == ST_SAVE && seq_last;
    wire seq_done = seq_ff != ST_IDLE && seq_last;

    // save walks pending into memory, undo walks it back
    always_comb begin
        nxt_seq = seq_ff;
        nxt_idx = idx_ff;
        case (seq_ff)
            ST_IDLE: begin
                nxt_idx = '0;
                if (go_save) begin
                    nxt_seq = ST_SAVE;
                end else if (go_undo) begin
                    nxt_seq = ST_UNDO;
                end
            end
            ST_SAVE, ST_UNDO: begin
                nxt_idx = seq_last ? '0 : idx_ff + IW'(1);
                if (seq_last) begin
                    nxt_seq = ST_IDLE;
                end
            end
            default: begin
                nxt_seq = ST_IDLE;
            end
        endcase
    end

    // memory read follows the selection so saved data matches sel_ff
    wire [IW-1:0] mem_raddr = (seq_ff == ST_UNDO) ? idx_ff : nxt_sel;

    scc_cfg_mem #(.WIDTH(CFG_W), .DEPTH(NUM_PORTS), .AW(IW)) u_saved (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .we(seq_ff == ST_SAVE),
        .waddr(idx_ff),
        .wdata(pend_ff[idx_ff]),
        .raddr(mem_raddr),
        .rdata(saved_q)
    );

    // pending differs from saved until a walk finishes
    assign nxt_dirty = cfg_acc ? 1'b1 : (seq_done ? 1'b0 : dirty_ff);
    assign nxt_unsaved = (exit_req && dirty_ff) ? 1'b1 : (seq_done ? 1'b0 : unsaved_ff);

    // error flags held until the next checked write: cleared if accepted, reloaded if refused
    assign nxt_err = cfg_acc ? '0 : cfg_rej ? {ovl, slot_bad, range_bad} : err_ff;

    // =====================================================================
    // events and interrupt; a new event wins over the read clear
    wire [STAT_W-1:0] ev;
    assign ev[ST_SAVED] = save_done;
    assign ev[ST_RANGE] = cfg_rej && range_bad;
    assign ev[ST_SLOT] = cfg_rej && slot_bad;
    assign ev[ST_OVL] = cfg_rej && ovl;
    assign ev[ST_EXIT] = exit_req && dirty_ff;
    assign nxt_status = (status_rd ? '0 : status_ff) | ev;

    // =====================================================================
    // read mux
    logic [DATA_W-1:0] rd_mux;
    always_comb begin
        case (addr)
            ADDR_SEL: rd_mux = DATA_W'(sel_ff);
            ADDR_CFG: rd_mux = DATA_W'(cur_cfg);
            ADDR_SAVED: rd_mux = DATA_W'(saved_q);
            ADDR_STATUS: rd_mux = DATA_W'(status_ff);
            ADDR_MASK: rd_mux = DATA_W'(mask_ff);
            ADDR_LINK: rd_mux = DATA_W'(link_ff);
            ADDR_ERR: rd_mux = DATA_W'({busy, dirty_ff, err_ff});
            default: rd_mux = '0;
        endcase
    end

    // =====================================================================
    // registers
    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            sel_ff <= '0;
            status_ff <= '0;
            mask_ff <= '0;
            link_ff <= '0;
            err_ff <= '0;
            dirty_ff <= 1'b0;
            unsaved_ff <= 1'b0;
            irq_ff <= 1'b0;
            rdata_ff <= '0;
            seq_ff <= ST_SAVE;
            idx_ff <= '0;
            undo_vld_ff <= 1'b0;
            undo_idx_ff <= '0;
        end else begin
            sel_ff <= nxt_sel;
            status_ff <= nxt_status;
            mask_ff <= (wr_en && addr == ADDR_MASK) ? wdata[STAT_W-1:0] : mask_ff;
            link_ff <= (wr_en && addr == ADDR_LINK) ? wdata[1:0] : link_ff;
            err_ff <= nxt_err;
            dirty_ff <= nxt_dirty;
            unsaved_ff <= nxt_unsaved;
            irq_ff <= |(nxt_status & mask_ff);
            rdata_ff <= rd_en ? rd_mux : '0;
            seq_ff <= nxt_seq;
            idx_ff <= nxt_idx;
            undo_vld_ff <= seq_ff == ST_UNDO;
            undo_idx_ff <= idx_ff;
        end
    end

    // reset leaves every port in standby with defaults
    always_ff @(posedge ref_clk) begin
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (!resetn) begin
                pend_ff[i] <= CFG_DEFAULT;
            end else if (cfg_acc && sel_ff == IW'(i)) begin
                pend_ff[i] <= new_cfg;
            end else if (undo_vld_ff && undo_idx_ff == IW'(i)) begin
                pend_ff[i] <= saved_q;
            end
        end
    end

    assign rdata = rdata_ff;
    assign irq = irq_ff;
    assign unsaved = unsaved_ff;

    // =====================================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn);

    property p_ovl_needs_active;
        ovl |-> new_act && !is_srv;
    endproperty
    a_ovl_needs_active: assert property (p_ovl_needs_active) else $error("overlap on idle port");

    property p_srv_rate;
        cfg_acc && is_srv |=> pend_ff[sel_ff][RATE_LSB +: RATE_W] == R_56K ||
                              pend_ff[sel_ff][RATE_LSB +: RATE_W] == R_64K;
    endproperty
    a_srv_rate: assert property (p_srv_rate) else $error("server port took bad rate");

    property p_ts_range;
        cfg_acc && !is_srv |-> new_ts >= TS_FIRST && new_ts <= ts_max &&
            !(link_ff[LINK_E1] && link_ff[LINK_SIG] && new_ts == TS_E1_SIG);
    endproperty
    a_ts_range: assert property (p_ts_range) else $error("time slot out of range");

    property p_span_fits;
        cfg_acc |-> new_end <= {1'b0, frame_len(new_fr)} && new_cnt != 5'h00;
    endproperty
    a_span_fits: assert property (p_span_fits) else $error("span runs past frame");

    property p_overlap_flag;
        cfg_try && ovl |=> err_ff[ERR_OVL] && status_ff[ST_OVL] && $stable(pend_ff[sel_ff]);
    endproperty
    a_overlap_flag: assert property (p_overlap_flag) else $error("overlap not refused");

    property p_maj_rate;
        cfg_acc && new_ec == EC_MAJ |-> new_rate <= R_9K6;
    endproperty
    a_maj_rate: assert property (p_maj_rate) else $error("majority vote at high rate");

    property p_sw56_off;
        cfg_acc && new_rate == R_SW56 |-> new_ec == EC_OFF;
    endproperty
    a_sw56_off: assert property (p_sw56_off) else $error("correction on switched 56k");

    property p_bch_card;
        cfg_acc && new_ec == EC_BCH |-> VARIANT == VAR_TWO && new_rate >= R_19K2 &&
                                        new_rate <= R_64K;
    endproperty
    a_bch_card: assert property (p_bch_card) else $error("block code not allowed");

    property p_csu_card;
        cfg_acc && new_csu |-> VARIANT != VAR_FIVE;
    endproperty
    a_csu_card: assert property (p_csu_card) else $error("csu on five-port card");

    property p_walk_ends;
        go_save || go_undo |-> ##[1:24] !busy && !dirty_ff;
    endproperty
    a_walk_ends: assert property (p_walk_ends) else $error("save or undo did not end");

    property p_exit_flag;
        exit_req && dirty_ff |=> unsaved_ff && status_ff[ST_EXIT];
    endproperty
    a_exit_flag: assert property (p_exit_flag) else $error("unsaved exit not flagged");

    property p_err_hold;
        err_ff != '0 && !cfg_acc |=> err_ff == $past(err_ff) || $past(cfg_rej);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("error flag dropped early");

endmodule

/* File: verification/scc_seg_model.sv */
// partner model: segments one circuit needs inside a ds0 time slot
`timescale 1ns/1ps

module scc_seg_model import scc_pkg::*; (
    input wire logic [1:0] frame,
    input wire logic [2:0] rate,
    input wire logic [4:0] sub,
    output logic [4:0] need,
    output logic fits
);
    // ==========
    // frame size
    logic [4:0] segs;
    logic [2:0] unit;
    assign segs = (frame == FR_B5) ? SEGS_B5 : (frame == FR_B10) ? SEGS_B10 :
        (frame == FR_B20) ? SEGS_B20 : SEG_FIRST;
    // segment rate code: b-5 9.6k, b-10 4.8k, b-20 2.4k
    assign unit = 3'h3 - {1'b0, frame};
    // ==========
    // circuit width
    // wide circuits span segments
    always_comb begin
        need = 5'h01;
        if (frame != FR_A && rate > R_19K2) begin
            need = 5'h1F;
        end else if (frame != FR_A && rate > unit) begin
            need = 5'h01 << (rate - unit);
        end
    end
    // lowest segment, must end inside frame
    assign fits = (sub >= SEG_FIRST) && ({1'b0, sub} + {1'b0, need} - 6'h01 <= {1'b0, segs});
endmodule

/* File: verification/scc_port_cfg_tb.sv */
// self-checking bench for the port configuration checker
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
    $display("Error t=%0t got %h exp %h", $time, a, b); end end

module scc_port_cfg_tb import scc_pkg::*;;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic unsaved;
    int err_count = 0;
    int tests_run = 0;
    logic [31:0] d;
    logic [31:0] tw [8];
    logic [1:0] m_fr = 2'h0;
    logic [2:0] m_rt = 3'h0;
    logic [4:0] m_sub = 5'h01;
    logic [4:0] m_need;
    logic m_fits;
    logic [31:0] rdata5;
    int lk [5] = '{3, 3, 1, 0, 0};
    int ts [5] = '{16, 31, 16, 25, 24};

    always #50 ref_clk = ~ref_clk;

    scc_port_cfg uut (.ref_clk(ref_clk), .resetn(resetn), .addr(addr), .wdata(wdata),
        .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq), .unsaved(unsaved));
    scc_seg_model mdl (.frame(m_fr), .rate(m_rt), .sub(m_sub), .need(m_need), .fits(m_fits));
    // five-port card on the same bus: block code and csu must be refused there
    scc_port_cfg #(.VARIANT(VAR_FIVE)) uut_five (.ref_clk(ref_clk), .resetn(resetn),
        .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata5), .irq(),
        .unsaved());

    // ==========
    // access tasks
    function automatic logic [31:0] cw(logic a, logic [3:0] ds, logic [4:0] t, logic [1:0] f,
        logic [2:0] r, logic [4:0] s, logic m, logic [1:0] e);
        return {9'h000, e, m, s, r, f, t, ds, a};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge ref_clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge ref_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge ref_clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge ref_clk);
        rd_en <= 1'b0;
        #1 v = rdata;
    endtask
    // bounded poll: save walk takes about NUM_PORTS+1 cycles
    task automatic idle();
        int n;
        n = 0;
        do begin rd(ADDR_ERR, d); n++; end while (d[ERR_BUSY] !== 1'b0 && n < 50);
        `CHK(d[ERR_BUSY], 1'b0)
    endtask
    task automatic put(input logic [31:0] w, input logic [2:0] e);
        wr(ADDR_CFG, w);
        rd(ADDR_ERR, d);
        `CHK(d[2:0], e)
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========
    // tests
    initial begin
        tw = '{cw(0, 8, 1, FR_A, R_2K4, 1, 0, EC_OFF), cw(0, 10, 1, FR_A, R_64K, 1, 0, EC_OFF),
            cw(0, 0, 1, FR_A, R_19K2, 1, 0, EC_MAJ), cw(0, 0, 1, FR_A, R_9K6, 1, 0, EC_MAJ),
            cw(0, 0, 1, FR_A, R_SW56, 1, 0, EC_MAJ), cw(0, 0, 1, FR_A, R_2K4, 1, 0, EC_BCH),
            cw(0, 7, 1, FR_A, R_64K, 1, 0, EC_BCH), cw(0, 0, 1, FR_A, R_2K4, 1, 1, EC_OFF)};
        repeat (16) @(posedge ref_clk);
        `CHK({rdata, irq, unsaved}, 34'h0)
        resetn <= 1'b1;
        rd(ADDR_CFG, d);
        `CHK(d, cw(0, 0, 1, FR_A, R_2K4, 1, 0, EC_OFF))
        idle();
        wr(ADDR_MASK, 32'h1F);
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            put(tw[i], {2'b00, (i == 0 || i == 2 || i == 4 || i == 5)});
            `CHK(rdata5[ERR_RANGE], (i != 1 && i != 3))
        end
        put(tw[0], 3'b001);
        rd(ADDR_CFG, d);
        `CHK(d, tw[7])
        `CHK(irq, 1'b1)
        rd(ADDR_STATUS, d);
        `CHK(d[ST_RANGE], 1'b1)
        rd(ADDR_STATUS, d);
        `CHK({d[4:0], irq}, 6'h00)
        $display("test rate and correction done");
        for (int i = 0; i < 5; i++) begin
            wr(ADDR_LINK, 32'(lk[i]));
            d = cw(0, 0, 5'(ts[i]), FR_A, R_2K4, 1, 0, EC_OFF);
            put(d, {2'b00, (i == 0 || i == 3)});
        end
        $display("test time slot done");
        for (int f = 1; f < 4; f++) begin
            for (int s = 1; s <= (5 << (f - 1)); s++) begin
                m_fr = 2'(f);
                m_rt = R_19K2;
                m_sub = 5'(s);
                #1;
                `CHK(m_need, 5'(1 << f))
                put(cw(1, 0, 1, m_fr, m_rt, m_sub, 0, EC_OFF), {1'b0, ~m_fits, 1'b0});
            end
        end
        $display("test sub-rate slot done");
        put(cw(1, 0, 1, FR_B5, R_19K2, 1, 0, EC_OFF), 3'b000);
        wr(ADDR_SEL, 32'h1);
        put(cw(0, 0, 1, FR_B5, R_19K2, 1, 0, EC_OFF), 3'b000);
        put(cw(1, 0, 1, FR_B5, R_19K2, 2, 0, EC_OFF), 3'b100);
        put(cw(1, 0, 1, FR_B5, R_19K2, 3, 0, EC_OFF), 3'b000);
        $display("test overlap done");
        wr(ADDR_CMD, 32'h1);
        idle();
        rd(ADDR_SAVED, d);
        `CHK(d, cw(1, 0, 1, FR_B5, R_19K2, 3, 0, EC_OFF))
        put(cw(0, 3, 2, FR_A, R_64K, 1, 0, EC_OFF), 3'b000);
        wr(ADDR_CMD, 32'h4);
        rd(ADDR_STATUS, d);
        `CHK({unsaved, d[ST_EXIT]}, 2'b11)
        wr(ADDR_CMD, 32'h2);
        idle();
        rd(ADDR_CFG, d);
        `CHK(d, cw(1, 0, 1, FR_B5, R_19K2, 3, 0, EC_OFF))
        `CHK(unsaved, 1'b0)
        $display("test save undo done");
        wr(ADDR_MASK, 32'h0);
        put(tw[0], 3'b001);
        `CHK(irq, 1'b0)
        rd(ADDR_STATUS, d);
        `CHK(d[ST_RANGE], 1'b1)
        $display("test mask done");
        finish_test();
    end

    // hang guard, well beyond the few hundred cycles the tests need
    initial begin
        #(40000 * 100);
        err_count++;
        finish_test();
    end
endmodule
